// ---- pkg/stcp_pkg.sv ----
/*
 * Constants for the compensation parameter register group: register
 * addresses, field layouts, reset values and the motion tick timing.
 * Assumes a 100 MHz core clock and a command decoder that delivers
 * register values as whole bytes, most significant byte first.
 */
package stcp_pkg;

    // ==========================================================
    // Register addresses on the command port
    localparam logic [4:0] ADDR_INT_SPEED   = 5'h01;
    localparam logic [4:0] ADDR_START_SLOPE = 5'h02;
    localparam logic [4:0] ADDR_FSLOPE_ACC  = 5'h03;
    localparam logic [4:0] ADDR_FSLOPE_DEC  = 5'h04;
    localparam logic [4:0] ADDR_THERM_COEF  = 5'h05;
    localparam logic [4:0] ADDR_SUPPLY_ADC  = 5'h06;
    localparam logic [4:0] ADDR_OVERCURRENT = 5'h07;
    localparam logic [4:0] ADDR_STALL       = 5'h08;
    localparam logic [4:0] ADDR_STEP_CFG    = 5'h09;

    // ==========================================================
    // Field widths and positions
    localparam int INT_SPEED_W = 14;
    localparam int SLOPE_W     = 8;
    localparam int THERM_W     = 4;
    localparam int ADC_W       = 5;
    localparam int THR_W       = 5;
    localparam int STEP_W      = 8;
    localparam int VALUE_W     = 24;

    localparam int STEP_SYNC_EN_BIT = 7;
    localparam int STEP_SYNC_SEL_HI = 6;
    localparam int STEP_SYNC_SEL_LO = 4;
    localparam int STEP_ZERO_BIT    = 3;
    localparam int STEP_SEL_HI      = 2;
    localparam int STEP_SEL_LO      = 0;

    // ==========================================================
    // Reset values
    localparam logic [INT_SPEED_W-1:0] RST_INT_SPEED = 14'h0000;
    localparam logic [SLOPE_W-1:0]     RST_SLOPE     = 8'h00;
    localparam logic [THERM_W-1:0]     RST_THERM     = 4'h0;
    localparam logic [ADC_W-1:0]       RST_ADC       = 5'h10;
    localparam logic [THR_W-1:0]       RST_OCD       = 5'h00;
    localparam logic [THR_W-1:0]       RST_STALL     = 5'h00;
    localparam logic [STEP_W-1:0]      RST_STEP      = 8'h00;

    // ==========================================================
    // Supply ADC saturation codes and thermal factor base (1.0 = 32/32)
    localparam logic [ADC_W-1:0] ADC_SAT_HIGH    = 5'h18;
    localparam logic [ADC_W-1:0] ADC_SAT_LOW     = 5'h08;
    localparam logic [5:0]       THERM_FACTOR_ONE = 6'h20;

    // ==========================================================
    // Motion tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 250;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        STCP_CMD_IDLE,
        STCP_CMD_DATA
    } stcp_cmd_state_t;

endpackage

// ---- core/stcp_byte_assembler.sv ----
/*
 * Collects the data bytes of one register write, most significant
 * byte first, and presents the whole value only after the last byte.
 * Assumes a start pulse before the bytes and no new start mid-value.
 */
module stcp_byte_assembler
    import stcp_pkg::*;
#(
    parameter int VAL_W = VALUE_W
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_start,
    input  wire logic [1:0]       i_nbytes,
    input  wire logic             i_byte_valid,
    input  wire logic [7:0]       i_byte,
    output logic      [VAL_W-1:0] o_value,
    output logic                  o_done
);

    logic [1:0] left_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            left_reg <= 2'h0;
            o_value  <= '0;
            o_done   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                left_reg <= i_nbytes;
                o_value  <= '0;
            end else if (i_byte_valid && left_reg != 2'h0) begin
                o_value  <= {o_value[VAL_W-9:0], i_byte};
                left_reg <= left_reg - 2'h1;
                o_done   <= (left_reg == 2'h1);
            end
        end
    end

endmodule

// ---- core/stcp_param_regs.sv ----
/*
 * Compensation parameter register group of a microstepping controller.
 * Assumes a command decoder that issues an address strobe followed by
 * data bytes, and a motion engine that reports running and busy.
 */
// What this block does
// R01: Intersect speed register holds step per tick; tick is 250 ns.
// R02: Intersect speed and slope writes while running are dropped, error flag set.
// R03: Start slope register feeds compensation below intersect speed.
// R04: Acceleration final slope feeds compensation above intersect speed.
// R05: Deceleration final slope feeds compensation above intersect speed.
// R06: All three slopes zero disables back-EMF compensation.
// R07: Thermal code n gives factor one plus n thirty-seconds.
// R08: Supply ADC result keeps updating regardless of compensation enable.
// R09: Any write to supply ADC result is dropped, error flag set.
// R10: ADC code saturates at 11000 high and 01000 low.
// R11: Overcurrent threshold equals code plus one times 31.25 mV.
// R12: Stall threshold uses same code plus one encoding.
// R13: Step config: sync enable, sync select, zero bit, step select.
// R14: Step select codes 0 to 7 pick full to 1/128 step.
// R15: Step mode change resets electrical position to first microstep.
// R16: After step select change absolute position loses meaning.
// R17: Step config writes while running are dropped, error flag set.
// R18: Sync disabled: busy pin low during commands; enabled: sync clock.
// R19: Sync output follows electrical position bit seven minus select.
// R20: A written value takes effect only once fully received.
module stcp_param_regs
    import stcp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_b,
    input  wire logic                   i_cmd_valid,
    input  wire logic                   i_cmd_write,
    input  wire logic [4:0]             i_cmd_addr,
    input  wire logic                   i_byte_valid,
    input  wire logic [7:0]             i_byte,
    input  wire logic                   i_err_clear,
    input  wire logic                   i_motor_running,
    input  wire logic                   i_cmd_busy,
    input  wire logic [7:0]             i_electrical_position,
    input  wire logic                   i_adc_valid,
    input  wire logic [ADC_W-1:0]       i_adc_code,
    output logic      [VALUE_W-1:0]     o_rd_data,
    output logic                        o_rd_valid,
    output logic                        o_cmd_error,
    output logic                        o_tick,
    output logic      [INT_SPEED_W-1:0] o_int_speed,
    output logic      [SLOPE_W-1:0]     o_bemf_start_slope,
    output logic      [SLOPE_W-1:0]     o_bemf_final_slope_accel,
    output logic      [SLOPE_W-1:0]     o_bemf_final_slope_decel,
    output logic                        o_bemf_comp_en,
    output logic      [THERM_W-1:0]     o_thermal_drift_coef,
    output logic      [5:0]             o_thermal_factor,
    output logic      [ADC_W-1:0]       o_supply_adc_result,
    output logic      [ADC_W-1:0]       o_supply_adc_clamped,
    output logic      [THR_W-1:0]       o_overcurrent_threshold,
    output logic      [THR_W:0]         o_overcurrent_steps,
    output logic      [THR_W-1:0]       o_stall_threshold,
    output logic      [THR_W:0]         o_stall_steps,
    output logic      [STEP_W-1:0]      o_stepping_config,
    output logic                        o_electrical_position_reset,
    output logic                        o_busy_sync
);

    // ==========================================================
    // Address decoding
    function automatic logic [1:0] bytes_for(input logic [4:0] addr);
        unique case (addr)
            ADDR_INT_SPEED: bytes_for = 2'h2;
            default:        bytes_for = 2'h1;
        endcase
    endfunction

    function automatic logic run_locked(input logic [4:0] addr);
        run_locked = (addr == ADDR_INT_SPEED) || (addr == ADDR_START_SLOPE) ||
                     (addr == ADDR_FSLOPE_ACC) || (addr == ADDR_FSLOPE_DEC) ||
                     (addr == ADDR_STEP_CFG);
    endfunction

    function automatic logic is_mapped(input logic [4:0] addr);
        is_mapped = (addr >= ADDR_INT_SPEED) && (addr <= ADDR_STEP_CFG);
    endfunction

    // ==========================================================
    // Command sequencing
    stcp_cmd_state_t   state_reg;
    logic [4:0]        addr_reg;
    logic [VALUE_W-1:0] asm_value;
    logic              asm_done;
    logic              commit;
    logic              refuse;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= STCP_CMD_IDLE;
            addr_reg  <= 5'h00;
        end else begin
            unique case (state_reg)
                STCP_CMD_IDLE: if (i_cmd_valid && i_cmd_write) begin
                    addr_reg  <= i_cmd_addr;
                    state_reg <= STCP_CMD_DATA;
                end
                STCP_CMD_DATA: if (asm_done) begin
                    state_reg <= STCP_CMD_IDLE;
                end
            endcase
        end
    end

    stcp_byte_assembler #(
        .VAL_W (VALUE_W)
    ) u_asm (
        .i_core_clk   (i_core_clk),
        .i_rst_b      (i_rst_b),
        .i_start      (state_reg == STCP_CMD_IDLE && i_cmd_valid && i_cmd_write),
        .i_nbytes     (bytes_for(i_cmd_addr)),
        .i_byte_valid (i_byte_valid && state_reg == STCP_CMD_DATA),
        .i_byte       (i_byte),
        .o_value      (asm_value),
        .o_done       (asm_done)
    );

    // Refusal is judged when the last byte lands, against current motor state
    assign refuse = asm_done && ((run_locked(addr_reg) && i_motor_running) ||  // [R02] [R17]
                                 addr_reg == ADDR_SUPPLY_ADC ||               // [R09]
                                 !is_mapped(addr_reg));
    assign commit = asm_done && !refuse;                                      // [R20]

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_error <= 1'b0;
        end else if (refuse) begin
            o_cmd_error <= 1'b1;                                              // [R02] [R09]
        end else if (i_err_clear) begin
            o_cmd_error <= 1'b0;
        end
    end

    // ==========================================================
    // Parameter registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_int_speed              <= RST_INT_SPEED;
            o_bemf_start_slope       <= RST_SLOPE;
            o_bemf_final_slope_accel <= RST_SLOPE;
            o_bemf_final_slope_decel <= RST_SLOPE;
            o_thermal_drift_coef     <= RST_THERM;
            o_overcurrent_threshold  <= RST_OCD;
            o_stall_threshold        <= RST_STALL;
            o_stepping_config        <= RST_STEP;
        end else if (commit) begin
            unique case (addr_reg)
                ADDR_INT_SPEED:   o_int_speed <= asm_value[INT_SPEED_W-1:0];            // [R01]
                ADDR_START_SLOPE: o_bemf_start_slope <= asm_value[SLOPE_W-1:0];         // [R03]
                ADDR_FSLOPE_ACC:  o_bemf_final_slope_accel <= asm_value[SLOPE_W-1:0];   // [R04]
                ADDR_FSLOPE_DEC:  o_bemf_final_slope_decel <= asm_value[SLOPE_W-1:0];   // [R05]
                ADDR_THERM_COEF:  o_thermal_drift_coef <= asm_value[THERM_W-1:0];
                ADDR_OVERCURRENT: o_overcurrent_threshold <= asm_value[THR_W-1:0];
                ADDR_STALL:       o_stall_threshold <= asm_value[THR_W-1:0];
                // The zero bit is forced so a careless host cannot set it
                ADDR_STEP_CFG:    o_stepping_config <= asm_value[STEP_W-1:0] &
                                                       ~(8'h01 << STEP_ZERO_BIT);      // [R13]
                default:          o_int_speed <= o_int_speed;
            endcase
        end
    end

    // ==========================================================
    // Derived compensation and threshold values
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bemf_comp_en       <= 1'b0;
            o_thermal_factor     <= THERM_FACTOR_ONE;
            o_overcurrent_steps  <= 6'h01;
            o_stall_steps        <= 6'h01;
        end else begin
            o_bemf_comp_en <= (o_bemf_start_slope | o_bemf_final_slope_accel |
                               o_bemf_final_slope_decel) != '0;                 // [R06]
            o_thermal_factor    <= THERM_FACTOR_ONE + {2'h0, o_thermal_drift_coef};  // [R07]
            o_overcurrent_steps <= {1'b0, o_overcurrent_threshold} + 6'h01;          // [R11]
            o_stall_steps       <= {1'b0, o_stall_threshold} + 6'h01;                // [R12]
        end
    end

    // Conversion result is taken every sample, independent of compensation enable
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_supply_adc_result  <= RST_ADC;
            o_supply_adc_clamped <= RST_ADC;
        end else begin
            if (i_adc_valid) begin
                o_supply_adc_result <= i_adc_code;                                // [R08]
            end
            if (o_supply_adc_result >= ADC_SAT_HIGH) begin
                o_supply_adc_clamped <= ADC_SAT_HIGH;                             // [R10]
            end else if (o_supply_adc_result <= ADC_SAT_LOW) begin
                o_supply_adc_clamped <= ADC_SAT_LOW;                              // [R10]
            end else begin
                o_supply_adc_clamped <= o_supply_adc_result;
            end
        end
    end

    // ==========================================================
    // Step mode, electrical position reset and busy/sync pin
    logic [2:0] step_sel_prev;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            step_sel_prev  <= RST_STEP[STEP_SEL_HI:STEP_SEL_LO];
            o_electrical_position_reset <= 1'b0;
        end else begin
            step_sel_prev  <= o_stepping_config[STEP_SEL_HI:STEP_SEL_LO];   // [R14]
            // Also tells the host side that absolute position is stale
            o_electrical_position_reset <= step_sel_prev !=
                              o_stepping_config[STEP_SEL_HI:STEP_SEL_LO];   // [R15] [R16]
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_busy_sync <= 1'b1;
        end else if (o_stepping_config[STEP_SYNC_EN_BIT]) begin
            o_busy_sync <= i_electrical_position[3'h7 -
                           o_stepping_config[STEP_SYNC_SEL_HI:STEP_SYNC_SEL_LO]];   // [R18] [R19]
        end else begin
            o_busy_sync <= !i_cmd_busy;                                             // [R18]
        end
    end

    // ==========================================================
    // Motion tick divider
    logic [7:0] tick_cnt;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt <= 8'h00;
            o_tick   <= 1'b0;
        end else begin
            o_tick   <= (tick_cnt == 8'(TICK_CYCLES - 1));                  // [R01]
            tick_cnt <= (tick_cnt == 8'(TICK_CYCLES - 1)) ? 8'h00 : tick_cnt + 8'h01;
        end
    end

    // ==========================================================
    // Register reads
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_cmd_valid && !i_cmd_write && state_reg == STCP_CMD_IDLE;
            if (i_cmd_valid && !i_cmd_write && state_reg == STCP_CMD_IDLE) begin
                unique case (i_cmd_addr)
                    ADDR_INT_SPEED:   o_rd_data <= VALUE_W'(o_int_speed);
                    ADDR_START_SLOPE: o_rd_data <= VALUE_W'(o_bemf_start_slope);
                    ADDR_FSLOPE_ACC:  o_rd_data <= VALUE_W'(o_bemf_final_slope_accel);
                    ADDR_FSLOPE_DEC:  o_rd_data <= VALUE_W'(o_bemf_final_slope_decel);
                    ADDR_THERM_COEF:  o_rd_data <= VALUE_W'(o_thermal_drift_coef);
                    ADDR_SUPPLY_ADC:  o_rd_data <= VALUE_W'(o_supply_adc_result);
                    ADDR_OVERCURRENT: o_rd_data <= VALUE_W'(o_overcurrent_threshold);
                    ADDR_STALL:       o_rd_data <= VALUE_W'(o_stall_threshold);
                    ADDR_STEP_CFG:    o_rd_data <= VALUE_W'(o_stepping_config);
                    default:          o_rd_data <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_locked_done;
        asm_done && run_locked(addr_reg) && i_motor_running;
    endsequence

    a_locked_refused: assert property (s_locked_done |=> o_cmd_error && $stable(o_int_speed)
        && $stable(o_stepping_config)) else $error("locked write not refused"); // [R02] [R17]
    a_adc_write_err: assert property (asm_done && addr_reg == ADDR_SUPPLY_ADC
        |=> o_cmd_error && ($stable(o_supply_adc_result) || $past(i_adc_valid)))
        else $error("adc write not refused"); // [R09]
    a_partial_hold: assert property (!asm_done |=> $stable(o_bemf_start_slope)
        && $stable(o_int_speed)) else $error("value changed before complete"); // [R20]
    a_bemf_off: assert property (o_bemf_start_slope == '0 && o_bemf_final_slope_accel == '0
        && o_bemf_final_slope_decel == '0 |=> !o_bemf_comp_en)
        else $error("compensation not disabled"); // [R06]
    a_thermal_map: assert property (##1 o_thermal_factor ==
        THERM_FACTOR_ONE + {2'h0, $past(o_thermal_drift_coef)}) else $error("thermal map"); // [R07]
    a_adc_follow: assert property (i_adc_valid |=> o_supply_adc_result == $past(i_adc_code)
        ##1 o_supply_adc_clamped >= ADC_SAT_LOW && o_supply_adc_clamped <= ADC_SAT_HIGH)
        else $error("adc result or clamp wrong"); // [R08] [R10]
    a_thr_encode: assert property (##1 o_overcurrent_steps ==
        {1'b0, $past(o_overcurrent_threshold)} + 6'h01 && o_stall_steps ==
        {1'b0, $past(o_stall_threshold)} + 6'h01) else $error("threshold encode"); // [R11] [R12]
    a_electrical_position_reset: assert property ($changed(o_stepping_config[STEP_SEL_HI:STEP_SEL_LO])
        |=> o_electrical_position_reset) else $error("no position reset"); // [R15]
    a_zero_bit: assert property (!o_stepping_config[STEP_ZERO_BIT])
        else $error("zero bit set"); // [R13]
    a_busy_low: assert property (!o_stepping_config[STEP_SYNC_EN_BIT] && i_cmd_busy
        |=> !o_busy_sync) else $error("busy not low"); // [R18]
    a_sync_source: assert property (o_stepping_config[STEP_SYNC_EN_BIT] |=> o_busy_sync ==
        $past(i_electrical_position[3'h7 - o_stepping_config[6:4]]))
        else $error("sync source wrong"); // [R19]
    a_tick_gap: assert property (o_tick |=> !o_tick [*8]) else $error("tick too soon"); // [R01]

endmodule

// ---- test/stcp_host_model.sv ----
/*
 * Host side of the command port: issues register commands byte by byte.
 * Assumes the register group samples on the rising edge; all changes
 * are made on the falling edge and held across one full cycle.
 */
module stcp_host_model
    import stcp_pkg::*;
(
    input  wire logic       i_core_clk,
    output logic            o_cmd_valid,
    output logic            o_cmd_write,
    output logic      [4:0] o_cmd_addr,
    output logic            o_byte_valid,
    output logic      [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cmd_valid  = 1'b0;
        o_cmd_write  = 1'b0;
        o_cmd_addr   = 5'h00;
        o_byte_valid = 1'b0;
        o_byte       = 8'h00;
    end

    // ==========================================================
    // One command; a write sends whole bytes, MSB first
    task automatic send(input logic wr, input logic [4:0] a, input logic [15:0] v);
        int nb;
        logic [15:0] val;
        nb  = !wr ? 0 : (a == ADDR_INT_SPEED) ? 2 : 1;
        val = v;
        if (a == ADDR_STEP_CFG) val[STEP_ZERO_BIT] = 1'b0;
        @(negedge i_core_clk);
        o_cmd_valid = 1'b1;
        o_cmd_write = wr;
        o_cmd_addr  = a;
        for (int i = nb - 1; i >= 0; i--) begin
            @(negedge i_core_clk);
            o_cmd_valid  = 1'b0;
            o_byte_valid = 1'b1;
            o_byte       = val[i*8 +: 8];
        end
        @(negedge i_core_clk);
        // Released address and byte lines show garbage, never the last value
        o_cmd_valid  = 1'b0;
        o_byte_valid = 1'b0;
        o_byte       = ~o_byte;
        o_cmd_addr   = ~o_cmd_addr;
    endtask
endmodule

// ---- test/tb_stcp_param_regs.sv ----
/*
 * Self-checking bench for the compensation parameter register group.
 * Assumes a 100 MHz clock; the motion engine inputs are driven here.
 */
module tb_stcp_param_regs import stcp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_err_clear = 1'b0, i_motor_running = 1'b0;
    logic i_cmd_busy = 1'b0, i_adc_valid = 1'b0;
    logic [7:0] i_electrical_position = 8'h00;
    logic [ADC_W-1:0] i_adc_code = 5'h00;
    logic cmd_valid, cmd_write, byte_valid, o_rd_valid, o_cmd_error, o_tick;
    logic o_bemf_comp_en, o_electrical_position_reset, o_busy_sync;
    logic [4:0] cmd_addr;
    logic [7:0] byte_data;
    logic [VALUE_W-1:0] o_rd_data;
    logic [INT_SPEED_W-1:0] o_int_speed;
    logic [SLOPE_W-1:0] o_s0, o_sa, o_sd;
    logic [THERM_W-1:0] o_therm;
    logic [5:0] o_tfac, o_ocs, o_sts;
    logic [ADC_W-1:0] o_adc, o_adcc, o_ocd, o_stl;
    logic [STEP_W-1:0] o_step;
    int n_errors = 0, cmp_count = 0, n_pos_rst = 0, n_tick = 0, tick0 = 0;

    always #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) n_pos_rst <= n_pos_rst + int'(o_electrical_position_reset === 1'b1);
    always @(posedge i_core_clk) n_tick <= n_tick + int'(o_tick === 1'b1);

    stcp_host_model u_host (.i_core_clk(i_core_clk), .o_cmd_valid(cmd_valid),
        .o_cmd_write(cmd_write), .o_cmd_addr(cmd_addr), .o_byte_valid(byte_valid),
        .o_byte(byte_data));

    stcp_param_regs uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid),
        .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_byte_valid(byte_valid),
        .i_byte(byte_data), .i_err_clear(i_err_clear), .i_motor_running(i_motor_running),
        .i_cmd_busy(i_cmd_busy), .i_electrical_position(i_electrical_position),
        .i_adc_valid(i_adc_valid), .i_adc_code(i_adc_code), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_cmd_error(o_cmd_error), .o_tick(o_tick),
        .o_int_speed(o_int_speed), .o_bemf_start_slope(o_s0), .o_bemf_final_slope_accel(o_sa),
        .o_bemf_final_slope_decel(o_sd), .o_bemf_comp_en(o_bemf_comp_en),
        .o_thermal_drift_coef(o_therm), .o_thermal_factor(o_tfac), .o_supply_adc_result(o_adc),
        .o_supply_adc_clamped(o_adcc), .o_overcurrent_threshold(o_ocd),
        .o_overcurrent_steps(o_ocs), .o_stall_threshold(o_stl), .o_stall_steps(o_sts),
        .o_stepping_config(o_step), .o_electrical_position_reset(o_electrical_position_reset), .o_busy_sync(o_busy_sync));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        u_host.send(1'b1, a, v);
        repeat (3) @(negedge i_core_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [23:0] exp);
        u_host.send(1'b0, a, 16'h0000);
        chk("rd_valid", 24'(o_rd_valid), 24'h1);
        chk("rd_data", o_rd_data, exp);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        finish_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (8) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        chk("busy_sync idle", 24'(o_busy_sync), 24'h1);
        rd(ADDR_SUPPLY_ADC, 24'h10);
        rd(ADDR_STEP_CFG, 24'h0);
        rd(ADDR_INT_SPEED, 24'h0);
        chk("comp_en reset", 24'(o_bemf_comp_en), 24'h0);
        wr(ADDR_INT_SPEED, 16'hffff);
        rd(ADDR_INT_SPEED, 24'h3fff);
        tick0 = n_tick;
        repeat (250) @(negedge i_core_clk);
        chk("ticks in 250 cycles", 24'(n_tick - tick0), 24'(250 / TICK_CYC));
        chk("int speed", o_int_speed, 24'h3fff);
        wr(ADDR_START_SLOPE, 16'h0081);
        chk("start slope", o_s0, 24'h81);
        chk("comp_en on", 24'(o_bemf_comp_en), 24'h1);
        wr(ADDR_START_SLOPE, 16'h0000);
        wr(ADDR_FSLOPE_ACC, 16'h00ff);
        chk("accel slope", o_sa, 24'hff);
        wr(ADDR_FSLOPE_ACC, 16'h0000);
        wr(ADDR_FSLOPE_DEC, 16'h0001);
        chk("decel slope", o_sd, 24'h01);
        wr(ADDR_FSLOPE_DEC, 16'h0000);
        chk("comp_en off", 24'(o_bemf_comp_en), 24'h0);
        wr(ADDR_THERM_COEF, 16'h000f);
        chk("thermal factor", o_tfac, 24'h2f);
        chk("thermal coef", o_therm, 24'hf);
        wr(ADDR_OVERCURRENT, 16'h001f);
        chk("ocd steps", o_ocs, 24'h20);
        chk("ocd code", o_ocd, 24'h1f);
        wr(ADDR_STALL, 16'h001e);
        chk("stall steps", o_sts, 24'h1f);
        chk("stall code", o_stl, 24'h1e);
        chk("error none", 24'(o_cmd_error), 24'h0);
        wr(ADDR_SUPPLY_ADC, 16'h0003);
        rd(ADDR_SUPPLY_ADC, 24'h10);
        chk("error adc write", 24'(o_cmd_error), 24'h1);
        i_err_clear = 1'b1;
        @(negedge i_core_clk);
        i_err_clear = 1'b0;
        @(negedge i_core_clk);
        chk("error cleared", 24'(o_cmd_error), 24'h0);
        i_motor_running = 1'b1;
        wr(ADDR_FSLOPE_DEC, 16'h0055);
        chk("locked slope", o_sd, 24'h00);
        chk("error running", 24'(o_cmd_error), 24'h1);
        wr(ADDR_STEP_CFG, 16'h0003);
        chk("locked step cfg", o_step, 24'h00);
        i_motor_running = 1'b0;
        i_adc_valid = 1'b1;
        i_adc_code = 5'h1c;
        @(negedge i_core_clk);
        i_adc_code = 5'h03;
        @(negedge i_core_clk);
        chk("adc high clamp", o_adcc, 24'h18);
        i_adc_valid = 1'b0;
        @(negedge i_core_clk);
        chk("adc result", o_adc, 24'h03);
        chk("adc low clamp", o_adcc, 24'h08);
        for (int s = 1; s < 8; s++) begin
            wr(ADDR_STEP_CFG, 16'(s) | 16'h0008);
            chk("step select", o_step, 24'(s));
        end
        chk("electrical_position resets", 24'(n_pos_rst), 24'd7);
        i_cmd_busy = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk("busy low", 24'(o_busy_sync), 24'h0);
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_STEP_CFG, 16'h0087 | 16'(s << 4));
            i_electrical_position = 8'h01 << (7 - s);
            repeat (2) @(negedge i_core_clk);
            chk("sync high", 24'(o_busy_sync), 24'h1);
            i_electrical_position = ~(8'h01 << (7 - s));
            repeat (2) @(negedge i_core_clk);
            chk("sync low", 24'(o_busy_sync), 24'h0);
        end
        chk("electrical_position no change", 24'(n_pos_rst), 24'd7);
        finish_test();
    end
endmodule
